/* hw/pcih_port.sv */
// Bus host port: config target, single-word master, parity and side-band pins
`timescale 1ns/1ns
`default_nettype none
`include "pcih_defines.svh"
// Functional notes
// R1 - Parity is even over all AD lines, C/BE lines and PAR together.
// R2 - PAR is driven one cycle after AD is driven, else it is input.
// R3 - The initiator asserts FRAME at start and holds it through the burst.
// R4 - The claiming target asserts TRDY when the data phase can complete.
// R5 - The master asserts IRDY when write data is valid or read can accept.
// R6 - REQ is asserted toward the arbiter whenever a master transfer is needed.
// R7 - No master transaction starts without GNT from the arbiter.
// R8 - Configuration accesses are claimed only while IDSEL is asserted.
// R9 - DEVSEL is driven active once the address is decoded as ours.
// R10 - A target needing to end asserts STOP; the master then terminates.
// R11 - PME output signals a power management event.
// R12 - CLKRUN is sampled for clock state and driven to request the clock.
// R13 - Interrupt requests are signalled on the INTA output.
// R14 - PERR reports data parity errors except in special cycles.
// R15 - PERR is driven only while receiving AD and PAR.
// R16 - SERR is driven on address parity errors and catastrophic errors. Only address parity errors drive it here.
// R17 - Bus logic runs on the 33 MHz bus clock, reset by the bus reset.
// R18 - Bus pins sampled and driven on rising edge; all floated during reset. REQ is driven high during reset instead.
module pcih_port
  import pcih_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic pclk,
  input wire logic bus_reset_in_n,
  input wire pcih_bus_in_t bi,
  output pcih_bus_out_t bo,
  input wire logic clkrun_n_in,
  output logic clkrun_oe,
  output logic bus_clk_stopped,
  output logic inta_n,
  output logic pme_oe,
  input wire logic intr_req,
  input wire logic pme_req,
  input wire logic job_valid,
  input wire pcih_job_t job,
  output logic job_ready,
  output logic res_valid,
  output pcih_res_t res
);
  function automatic logic par36(input logic [31:0] a, input logic [3:0] c);
    par36 = ^{a, c};
  endfunction

  // ****************************************
  // System clock side
  // ****************************************
  pcih_job_t job_q;
  logic req_tgl;
  logic done_s1, done_s2, done_s3;
  logic ckr_s1, ckr_s2;
  logic [3:0] ckr_cnt;
  logic done_tgl;
  pcih_res_t res_x;

  always_ff @(posedge clk)
    if (sys_rst)
    begin
      job_ready <= 1'b1;
      req_tgl <= 1'b0;
      res_valid <= 1'b0;
      res <= '0;
      job_q <= '0;
    end
    else
    begin
      res_valid <= done_s2 ^ done_s3;
      if (job_valid && job_ready)
      begin
        job_q <= job;
        req_tgl <= ~req_tgl;
        job_ready <= 1'b0;
      end
      else if (done_s2 ^ done_s3)
      begin
        res <= res_x;
        job_ready <= 1'b1;
      end
    end

  always_ff @(posedge clk)
    if (sys_rst)
      {done_s1, done_s2, done_s3, ckr_s1, ckr_s2} <= 5'h00;
    else
    begin
      done_s1 <= done_tgl;
      done_s2 <= done_s1;
      done_s3 <= done_s2;
      ckr_s1 <= clkrun_n_in;
      ckr_s2 <= ckr_s1;
    end

  // Clock may be stopped, so the request is made from the system clock
  always_ff @(posedge clk)
    if (sys_rst)
    begin
      ckr_cnt <= 4'h0;
      clkrun_oe <= 1'b0;
      bus_clk_stopped <= 1'b0;
    end
    else
    begin
      bus_clk_stopped <= ckr_s2; // R12
      clkrun_oe <= ckr_cnt != 4'h0; // R12
      if (ckr_cnt != 4'h0)
        ckr_cnt <= ckr_cnt - 4'h1;
      else if (ckr_s2 && !clkrun_oe && (!job_ready || intr_req || pme_req))
        ckr_cnt <= 4'(`PCIH_CLKRUN_CYC); // R12
    end

  always_ff @(posedge clk)
    if (sys_rst)
    begin
      inta_n <= 1'b1;
      pme_oe <= 1'b0;
    end
    else
    begin
      inta_n <= ~intr_req; // R13
      pme_oe <= pme_req; // R11
    end

  // ****************************************
  // Bus clock side
  // ****************************************
  pcih_tst_t tst;
  pcih_mst_t mst;
  logic [31:0] cfg [`PCIH_CFG_WORDS];
  logic [3:0] t_idx;
  logic t_wr;
  logic frame_q;
  logic rq1, rq2, rq3;
  logic [2:0] m_cnt;
  logic chk_valid, chk_pv, chk_mst, ap_chk, ap_pv;
  logic addr_seen, cfg_hit, t_done, m_hit, m_done, grant_ok, par_err;
  logic bme, per_en, serr_en;

  assign bme = cfg[`PCIH_CMD_IDX][`PCIH_BME_BIT];
  assign per_en = cfg[`PCIH_CMD_IDX][`PCIH_PER_BIT];
  assign serr_en = cfg[`PCIH_CMD_IDX][`PCIH_SERR_BIT];
  assign addr_seen = !bi.frame_n && frame_q;
  assign cfg_hit = tst == T_IDLE && addr_seen && bi.idsel && bi.ad[1:0] == 2'h0 // R8
    && (bi.cbe == `PCIH_CMD_CFG_RD || bi.cbe == `PCIH_CMD_CFG_WR);
  assign t_done = tst == T_DATA && !bi.irdy_n;
  assign m_hit = !bi.devsel_n && !bi.trdy_n;
  assign m_done = mst == M_DATA
    && (m_hit || !bi.stop_n || (bi.devsel_n && m_cnt == `PCIH_DEVSEL_WAIT));
  assign grant_ok = !bi.gnt_n && bi.frame_n && bi.irdy_n; // R7
  assign par_err = chk_valid && bi.par != chk_pv;

  always_ff @(posedge pclk)
    if (!bus_reset_in_n)
      {frame_q, rq1, rq2, rq3} <= 4'h8; // R17
    else
    begin
      frame_q <= bi.frame_n;
      rq1 <= req_tgl;
      rq2 <= rq1;
      rq3 <= rq2;
    end

  // Target: claims config cycles only, one data phase each
  always_ff @(posedge pclk)
    if (!bus_reset_in_n)
    begin
      tst <= T_IDLE;
      {bo.trdy_n, bo.devsel_n, bo.stop_n, bo.tctl_oe} <= 4'he; // R18
      t_idx <= 4'h0;
      t_wr <= 1'b0;
    end
    else
      case (tst)
        T_IDLE:
          if (cfg_hit)
          begin
            tst <= T_WAIT;
            t_wr <= bi.cbe[0];
            t_idx <= bi.ad[5:2];
            bo.devsel_n <= 1'b0; // R9
            bo.tctl_oe <= 1'b1;
          end
        T_WAIT:
        begin
          tst <= T_DATA;
          bo.trdy_n <= 1'b0; // R4
          bo.stop_n <= bi.frame_n; // R10
        end
        T_DATA:
          if (!bi.irdy_n)
          begin
            bo.trdy_n <= 1'b1;
            if (!bi.frame_n)
              tst <= T_HOLD;
            else
            begin
              {bo.devsel_n, bo.stop_n} <= 2'h3;
              tst <= T_TURN;
            end
          end
        T_HOLD:
          if (bi.frame_n)
          begin
            {bo.devsel_n, bo.stop_n} <= 2'h3; // R10
            tst <= T_TURN;
          end
        T_TURN:
        begin
          bo.tctl_oe <= 1'b0;
          tst <= T_IDLE;
        end
        default: tst <= T_IDLE;
      endcase

  always_ff @(posedge pclk)
    if (!bus_reset_in_n)
      for (int w = 0; w < `PCIH_CFG_WORDS; w++)
        cfg[w] <= `PCIH_CMD_RST;
    else if (t_done && t_wr)
      for (int b = 0; b < 4; b++)
        if (!bi.cbe[b])
          cfg[t_idx][8*b +: 8] <= bi.ad[8*b +: 8];

  // Master: one word per job, REQ held until the address phase
  always_ff @(posedge pclk)
    if (!bus_reset_in_n)
    begin
      mst <= M_IDLE;
      {bo.frame_n, bo.irdy_n, bo.mctl_oe, bo.req_n} <= 4'hd; // R18
      m_cnt <= 3'h0;
      done_tgl <= 1'b0;
      res_x <= '0;
    end
    else
      case (mst)
        M_IDLE:
          if (rq2 ^ rq3)
          begin
            if (bme)
            begin
              bo.req_n <= 1'b0; // R6
              mst <= M_REQ;
            end
            else
            begin
              res_x <= '{ST_OFF, 1'b0, 32'h0000_0000};
              done_tgl <= ~done_tgl;
            end
          end
        M_REQ:
          if (grant_ok)
          begin
            bo.frame_n <= 1'b0; // R3
            bo.mctl_oe <= 1'b1;
            bo.req_n <= 1'b1;
            mst <= M_ADDR;
          end
        M_ADDR:
        begin
          bo.frame_n <= 1'b1; // R3
          bo.irdy_n <= 1'b0; // R5
          m_cnt <= 3'h0;
          mst <= M_DATA;
        end
        M_DATA:
          if (m_done)
          begin
            bo.irdy_n <= 1'b1;
            res_x.data <= job_q.write ? job_q.data : bi.ad;
            res_x.status <= m_hit ? ST_OK : (!bi.stop_n ? ST_STOP : ST_ABORT); // R10
            mst <= M_TURN;
          end
          else
            m_cnt <= m_cnt + 3'h1;
        M_TURN:
        begin
          bo.mctl_oe <= 1'b0;
          res_x.perr <= par_err && chk_mst;
          done_tgl <= ~done_tgl;
          mst <= M_IDLE;
        end
        default: mst <= M_IDLE;
      endcase

  // Shared AD/C-BE drivers; a read holds AD off for the turnaround
  always_ff @(posedge pclk)
    if (!bus_reset_in_n)
    begin
      {bo.ad_oe, bo.cbe_oe} <= 2'h0; // R18
      bo.ad <= 32'h0000_0000;
      bo.cbe <= 4'h0;
    end
    else if (mst == M_REQ && grant_ok)
    begin
      bo.ad <= job_q.addr;
      bo.cbe <= job_q.write ? `PCIH_CMD_MEM_WR : `PCIH_CMD_MEM_RD;
      {bo.ad_oe, bo.cbe_oe} <= 2'h3;
    end
    else if (mst == M_ADDR)
    begin
      bo.ad <= job_q.data;
      bo.ad_oe <= job_q.write; // R5
      bo.cbe <= job_q.be_n;
    end
    else if (tst == T_WAIT)
    begin
      bo.ad <= cfg[t_idx];
      bo.ad_oe <= !t_wr;
    end
    else if (m_done || t_done)
      {bo.ad_oe, bo.cbe_oe} <= 2'h0;

  always_ff @(posedge pclk)
    if (!bus_reset_in_n)
    begin
      bo.par <= 1'b0;
      bo.par_oe <= 1'b0; // R18
    end
    else
    begin
      bo.par <= par36(bo.ad, bo.cbe_oe ? bo.cbe : bi.cbe); // R1
      bo.par_oe <= bo.ad_oe; // R2
    end

  // Only non-special cycles are ever received, so PERR covers them all
  always_ff @(posedge pclk)
    if (!bus_reset_in_n)
    begin
      {chk_valid, chk_pv, chk_mst, ap_chk, ap_pv} <= 5'h0;
      {bo.perr_n, bo.perr_oe, bo.serr_oe} <= 3'h4; // R18
    end
    else
    begin
      chk_valid <= (t_done && t_wr) || (mst == M_DATA && m_hit && !job_q.write); // R15
      chk_mst <= mst == M_DATA;
      chk_pv <= par36(bi.ad, bi.cbe);
      ap_chk <= addr_seen;
      ap_pv <= par36(bi.ad, bi.cbe);
      bo.perr_n <= !(par_err && per_en); // R14
      bo.perr_oe <= (par_err && per_en) || !bo.perr_n; // R15
      bo.serr_oe <= ap_chk && bi.par != ap_pv && serr_en && per_en; // R16
    end

  // ****************************************
  // Checks
  // ****************************************
  a_par_even: assert property (@(posedge pclk) disable iff (!bus_reset_in_n) // R1
    bo.par_oe && bo.cbe_oe && $past(bo.cbe_oe)
    |-> !(^{bo.par, $past(bo.ad), $past(bo.cbe)}))
    else $error("PAR not even");
  a_par_drive: assert property (@(posedge pclk) disable iff (!bus_reset_in_n) // R2
    $rose(bo.ad_oe) |=> bo.par_oe ##1 (bo.par_oe == $past(bo.ad_oe)))
    else $error("PAR not tied to AD");
  a_frame_hold: assert property (@(posedge pclk) disable iff (!bus_reset_in_n) // R3
    $fell(bo.frame_n) |=> bo.frame_n && !bo.irdy_n && bo.mctl_oe)
    else $error("FRAME not followed by IRDY");
  a_trdy_claim: assert property (@(posedge pclk) disable iff (!bus_reset_in_n) // R4
    bo.tctl_oe && !bo.trdy_n |-> !bo.devsel_n && $past(!bo.devsel_n))
    else $error("TRDY without DEVSEL");
  a_req_grant: assert property (@(posedge pclk) disable iff (!bus_reset_in_n) // R7
    $fell(bo.frame_n) |-> $past(!bi.gnt_n) && $past(!bo.req_n))
    else $error("FRAME without grant");
  a_cfg_idsel: assert property (@(posedge pclk) disable iff (!bus_reset_in_n) // R8
    tst == T_IDLE && addr_seen && !bi.idsel |=> bo.devsel_n && tst == T_IDLE)
    else $error("Claim without IDSEL");
  a_stop_burst: assert property (@(posedge pclk) disable iff (!bus_reset_in_n) // R10
    tst == T_WAIT && !bi.frame_n |=> !bo.stop_n until_with bi.frame_n)
    else $error("Burst not stopped");
  a_perr_recv: assert property (@(posedge pclk) disable iff (!bus_reset_in_n) // R15
    !bo.perr_n |-> $past(chk_valid) && !$past(bo.ad_oe, 2))
    else $error("PERR while driving");
  a_serr_addr: assert property (@(posedge pclk) disable iff (!bus_reset_in_n) // R16
    ap_chk && bi.par != ap_pv && serr_en && per_en |=> bo.serr_oe ##1 !bo.serr_oe)
    else $error("SERR not pulsed");
  a_mst_abort: assert property (@(posedge pclk) disable iff (!bus_reset_in_n) // R5
    $fell(bo.irdy_n) && bi.devsel_n ##1 bi.devsel_n [*6] |-> bo.irdy_n)
    else $error("IRDY held past abort");
  a_clkrun_req: assert property (@(posedge clk) disable iff (sys_rst) // R12
    $rose(clkrun_oe) |-> $past(ckr_s2, 2) ##1 clkrun_oe [*2])
    else $error("CLKRUN pulse wrong");
  a_inta_level: assert property (@(posedge clk) disable iff (sys_rst) // R13
    intr_req ##1 intr_req |-> !inta_n)
    else $error("INTA not asserted");
  c_cfg_read: cover property (@(posedge pclk) tst == T_DATA && !t_wr && !bi.irdy_n);
  c_cfg_write: cover property (@(posedge pclk) t_done && t_wr);
  c_mst_ok: cover property (@(posedge pclk) mst == M_DATA && m_hit);
  c_mst_abort: cover property (@(posedge pclk) m_done && bi.devsel_n && bi.stop_n);
endmodule
`default_nettype wire

/* hw/pcih_defines.svh */
// Constants of the bus host port
`ifndef PCIH_DEFINES_SVH
`define PCIH_DEFINES_SVH
`define PCIH_CMD_MEM_RD 4'h6
`define PCIH_CMD_MEM_WR 4'h7
`define PCIH_CMD_CFG_RD 4'ha
`define PCIH_CMD_CFG_WR 4'hb
`define PCIH_CFG_WORDS 16
`define PCIH_CMD_IDX 4'h1
`define PCIH_CMD_RST 32'h0000_0000
`define PCIH_BME_BIT 2
`define PCIH_PER_BIT 6
`define PCIH_SERR_BIT 8
`define PCIH_DEVSEL_WAIT 3'h5
`define PCIH_CLK_PERIOD_NS 10
`define PCIH_CLKRUN_NS 30
`define PCIH_CLKRUN_CYC ((`PCIH_CLKRUN_NS + `PCIH_CLK_PERIOD_NS - 1) / `PCIH_CLK_PERIOD_NS)
`endif

/* hw/pcih_pkg.sv */
// Types of the bus host port
package pcih_pkg;
  typedef enum logic [2:0] {T_IDLE, T_WAIT, T_DATA, T_HOLD, T_TURN} pcih_tst_t;
  typedef enum logic [2:0] {M_IDLE, M_REQ, M_ADDR, M_DATA, M_TURN} pcih_mst_t;
  typedef enum logic [1:0] {ST_OK, ST_STOP, ST_ABORT, ST_OFF} pcih_stat_t;
  typedef struct packed {
    logic [31:0] ad;
    logic [3:0] cbe;
    logic par;
    logic frame_n;
    logic irdy_n;
    logic trdy_n;
    logic devsel_n;
    logic stop_n;
    logic gnt_n;
    logic idsel;
  } pcih_bus_in_t;
  typedef struct packed {
    logic [31:0] ad;
    logic ad_oe;
    logic [3:0] cbe;
    logic cbe_oe;
    logic par;
    logic par_oe;
    logic frame_n;
    logic irdy_n;
    logic mctl_oe;
    logic trdy_n;
    logic devsel_n;
    logic stop_n;
    logic tctl_oe;
    logic perr_n;
    logic perr_oe;
    logic serr_oe;
    logic req_n;
  } pcih_bus_out_t;
  typedef struct packed {
    logic write;
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0] be_n;
  } pcih_job_t;
  typedef struct packed {
    pcih_stat_t status;
    logic perr;
    logic [31:0] data;
  } pcih_res_t;
endpackage

/* verification/pcih_host_model.sv */
// Bridge, arbiter and memory target model at the far side of the bus port
`timescale 1ns/1ns
`default_nettype none
module pcih_host_model
  import pcih_pkg::*;
(
  input wire logic pclk,
  input wire logic bus_rst_n,
  input wire pcih_bus_out_t bo,
  output wire pcih_bus_in_t bi
);
  // ****
  // Wire levels
  // ****
  logic [31:0] h_ad = 32'h0, ad_last = 32'h0, rd_word = 32'h0, m_addr, m_data;
  logic [3:0] h_cbe = 4'h0, cbe_last = 4'h0, m_be;
  logic h_par = 1'b0, par_last = 1'b0, h_ad_oe = 1'b0, h_cbe_oe = 1'b0, h_par_oe = 1'b0;
  logic h_frame_n = 1'b1, h_irdy_n = 1'b1, h_trdy_n = 1'b1, h_devsel_n = 1'b1;
  logic h_stop_n = 1'b1, h_idsel = 1'b0, prev_frame = 1'b1, m_rd, no_claim = 1'b0;
  logic stop_tgt = 1'b0;
  int gcnt = 0, n;
  // Released lines without pull-up show the inverse of their last level
  assign bi = '{ad: bo.ad_oe ? bo.ad : (h_ad_oe ? h_ad : ~ad_last),
    cbe: bo.cbe_oe ? bo.cbe : (h_cbe_oe ? h_cbe : ~cbe_last),
    par: bo.par_oe ? bo.par : (h_par_oe ? h_par : ~par_last),
    frame_n: bo.mctl_oe ? bo.frame_n : h_frame_n, irdy_n: bo.mctl_oe ? bo.irdy_n : h_irdy_n,
    trdy_n: bo.tctl_oe ? bo.trdy_n : h_trdy_n, devsel_n: bo.tctl_oe ? bo.devsel_n : h_devsel_n,
    stop_n: bo.tctl_oe ? bo.stop_n : h_stop_n, gnt_n: gcnt < 3, idsel: h_idsel};
  always @(posedge pclk)
  begin
    {ad_last, cbe_last, par_last, prev_frame} <= {bi.ad, bi.cbe, bi.par, bi.frame_n};
  end
  // Slow grant, only while requested
  always @(negedge pclk) gcnt <= (bo.req_n || !bus_rst_n) ? 0 : gcnt + 1;
  // ****
  // Memory target
  // ****
  initial forever
  begin
    @(posedge pclk);
    if (bus_rst_n && bo.mctl_oe && !bi.frame_n && prev_frame && bi.cbe[3:1] == 3'b011 &&
      !no_claim)
    begin
      m_addr = bi.ad;
      m_rd = !bi.cbe[0];
      @(negedge pclk);
      h_devsel_n = 1'b0;
      @(negedge pclk);
      h_trdy_n = stop_tgt;
      h_stop_n = !stop_tgt;
      h_ad = rd_word;
      h_ad_oe = m_rd && !stop_tgt;
      for (n = 0; n < 16; n++)
      begin
        @(posedge pclk);
        if (!bi.irdy_n || stop_tgt) break;
      end
      {m_data, m_be} = {bi.ad, bi.cbe};
      @(negedge pclk);
      h_par = ^{h_ad, m_be};
      h_par_oe = h_ad_oe;
      {h_devsel_n, h_trdy_n, h_stop_n, h_ad_oe} = 4'b1110;
      @(negedge pclk);
      h_par_oe = 1'b0;
    end
  end
  // ****
  // Configuration initiator; bad flips address or data parity
  // ****
  task automatic cfg(input logic wr, input logic [3:0] idx, input logic [31:0] wd,
    input logic sel, input logic [1:0] bad, output logic [31:0] rd, output logic claimed);
    int k;
    claimed = 1'b0;
    @(negedge pclk);
    h_frame_n = 1'b0;
    h_ad = {26'h0, idx, 2'b00};
    h_cbe = wr ? 4'hb : 4'ha;
    {h_ad_oe, h_cbe_oe, h_idsel} = {2'b11, sel};
    @(negedge pclk);
    h_par = ^{h_ad, h_cbe} ^ bad[0];
    h_par_oe = 1'b1;
    {h_frame_n, h_irdy_n, h_idsel, h_cbe} = {3'b100, 4'h0};
    h_ad = wd;
    h_ad_oe = wr;
    for (k = 0; k < 8; k++)
    begin
      @(negedge pclk);
      if (k == 0)
      begin
        h_par = ^{h_ad, h_cbe} ^ bad[1];
        h_par_oe = wr;
      end
      claimed = claimed | !bi.devsel_n;
      if (!bi.trdy_n) break;
    end
    rd = bi.ad;
    @(negedge pclk);
    {h_irdy_n, h_ad_oe, h_cbe_oe} = 3'b100;
    @(negedge pclk);
    h_par_oe = 1'b0;
  endtask
endmodule
`default_nettype wire

/* verification/pcih_port_tb.sv */
// Self-checking bench of the bus host port
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module pcih_port_tb import pcih_pkg::*;;
  // ****
  // Harness
  // ****
  logic clk = 1'b0, sys_rst = 1'b1, pclk = 1'b0, bus_rst_n = 1'b0, ckr_host = 1'b0;
  logic intr_req = 1'b0, pme_req = 1'b0, job_valid = 1'b0, perr_seen = 1'b0;
  logic serr_seen = 1'b0, par_prev = 1'b0, oe_prev = 1'b0;
  logic job_ready, res_valid, clkrun_oe, stopped, inta_n, pme_oe;
  logic [31:0] rd;
  pcih_job_t job = '0;
  pcih_bus_out_t bo;
  pcih_res_t res, r;
  wire pcih_bus_in_t bi;
  wire logic ckr_wire;
  int failures = 0, checks_done = 0, cyc = 0, n;
  // Wire is low while either party pulls it
  assign ckr_wire = ckr_host && !clkrun_oe;
  always #5 clk = !clk;
  always #24 pclk = !pclk;
  pcih_port pcih_port_inst (.clk(clk), .sys_rst(sys_rst), .pclk(pclk),
    .bus_reset_in_n(bus_rst_n), .bi(bi), .bo(bo), .clkrun_n_in(ckr_wire),
    .clkrun_oe(clkrun_oe), .bus_clk_stopped(stopped), .inta_n(inta_n), .pme_oe(pme_oe),
    .intr_req(intr_req), .pme_req(pme_req), .job_valid(job_valid), .job(job),
    .job_ready(job_ready), .res_valid(res_valid), .res(res));
  pcih_host_model pcih_host_model_inst (.pclk(pclk), .bus_rst_n(bus_rst_n), .bo(bo), .bi(bi));
  always @(posedge pclk)
  begin
    if (bo.par_oe) `CHK({bo.par, oe_prev}, {par_prev, 1'b1})
    par_prev <= ^{bi.ad, bi.cbe};
    oe_prev <= bo.ad_oe;
    if (bo.perr_oe && !bo.perr_n) perr_seen <= 1'b1;
    if (bo.serr_oe) serr_seen <= 1'b1;
  end
  // Central clock resource answers a restart request by holding the wire low
  always @(negedge clk) if (clkrun_oe) ckr_host <= 1'b0;
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      failures++;
      report_and_stop();
    end
  end
  // ****
  // Scenarios
  // ****
  task automatic job_run(input logic wr, input logic [31:0] d, input logic [3:0] be);
    @(negedge clk);
    job = '{write: wr, addr: 32'h0000_1000, data: d, be_n: be};
    job_valid = 1'b1;
    @(negedge clk);
    job_valid = 1'b0;
    for (n = 0; n < 3000 && res_valid !== 1'b1; n++) @(negedge clk);
    r = res;
  endtask
  task automatic t_reset();
    repeat (10) @(negedge clk);
    `CHK({bo.ad_oe, bo.cbe_oe, bo.par_oe, bo.mctl_oe, bo.tctl_oe, bo.perr_oe, bo.serr_oe, bo.req_n}, 8'h01)
    `CHK({job_ready, res_valid, clkrun_oe, inta_n, pme_oe}, 5'h12)
    repeat (10) @(negedge clk);
    sys_rst = 1'b0;
    repeat (2) @(negedge pclk);
    bus_rst_n = 1'b1;
  endtask
  task automatic t_cfg();
    logic c;
    pcih_host_model_inst.cfg(1'b1, 4'h1, 32'h0000_0144, 1'b0, 2'b00, rd, c);
    `CHK(c, 1'b0)
    pcih_host_model_inst.cfg(1'b1, 4'h3, 32'h1234_5678, 1'b1, 2'b00, rd, c);
    `CHK(c, 1'b1)
    pcih_host_model_inst.cfg(1'b0, 4'h3, 32'h0, 1'b1, 2'b00, rd, c);
    `CHK(rd, 32'h1234_5678)
    pcih_host_model_inst.cfg(1'b0, 4'h1, 32'h0, 1'b1, 2'b00, rd, c);
    `CHK(rd, 32'h0)
    job_run(1'b1, 32'h0, 4'h0);
    `CHK(r.status, ST_OFF)
  endtask
  task automatic t_master();
    logic c;
    pcih_host_model_inst.cfg(1'b1, 4'h1, 32'h0000_0144, 1'b1, 2'b00, rd, c);
    {perr_seen, serr_seen} = 2'b00;
    job_run(1'b1, 32'hcafe_0001, 4'h2);
    `CHK({r.status, pcih_host_model_inst.m_addr, pcih_host_model_inst.m_data}, {ST_OK, 32'h0000_1000, 32'hcafe_0001})
    `CHK(pcih_host_model_inst.m_be, 4'h2)
    pcih_host_model_inst.rd_word = 32'ha5a5_5a5a;
    job_run(1'b0, 32'h0, 4'h0);
    `CHK({r.status, r.perr, r.data}, {ST_OK, 1'b0, 32'ha5a5_5a5a})
    `CHK({perr_seen, serr_seen}, 2'b00)
    pcih_host_model_inst.stop_tgt = 1'b1;
    job_run(1'b1, 32'h0, 4'h0);
    `CHK(r.status, ST_STOP)
    {pcih_host_model_inst.stop_tgt, pcih_host_model_inst.no_claim} = 2'b01;
    job_run(1'b0, 32'h0, 4'h0);
    `CHK(r.status, ST_ABORT)
    pcih_host_model_inst.no_claim = 1'b0;
  endtask
  task automatic t_parity();
    logic c;
    {perr_seen, serr_seen} = 2'b00;
    pcih_host_model_inst.cfg(1'b1, 4'h2, 32'h0f0f_0f0f, 1'b1, 2'b10, rd, c);
    repeat (3) @(negedge pclk);
    `CHK({perr_seen, serr_seen}, 2'b10)
    pcih_host_model_inst.cfg(1'b1, 4'h2, 32'h0, 1'b1, 2'b01, rd, c);
    repeat (3) @(negedge pclk);
    `CHK(serr_seen, 1'b1)
  endtask
  task automatic t_side();
    int cnt;
    cnt = 0;
    ckr_host = 1'b1;
    repeat (6) @(negedge clk);
    `CHK({stopped, clkrun_oe, inta_n, pme_oe}, 4'b1010)
    intr_req = 1'b1;
    repeat (20) @(negedge clk) cnt += clkrun_oe;
    `CHK(cnt, 3)
    `CHK(inta_n, 1'b0)
    pme_req = 1'b1;
    repeat (2) @(negedge clk);
    `CHK(pme_oe, 1'b1)
    {intr_req, pme_req} = 2'b00;
    repeat (2) @(negedge clk);
    `CHK({inta_n, pme_oe}, 2'b10)
  endtask
  initial
  begin
    t_reset();
    t_cfg();
    t_master();
    t_parity();
    t_side();
    report_and_stop();
  end
  task automatic report_and_stop();
    $display("checks_done=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
endmodule
`default_nettype wire
